// >>> design/cmrc_top.sv
// Clock source, instruction clock and system reset sequencing of the microcontroller.
`timescale 1ns/100ps
`include "cmrc_map.svh"
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
module cmrc_top #(
  parameter int WARMUP_EDGES = `CMRC_WARM_EDGES
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Pins and oscillator inputs, asynchronous
  input  wire logic                resetPinN,
  input  wire logic                extOscIn,
  input  wire logic                ircIn,
  input  wire logic                slowRcIn,
  input  wire logic                wakeupPin,
  // Configuration options, static
  input  wire logic                resetPinEnable,
  input  wire logic                highClockOption,
  input  wire logic                noiseFilter,
  input  wire logic [3:0]          divSelect,
  // Watchdog, same clock
  input  wire logic                watchdogOverflow,
  // Register port
  input  wire logic [7:0]          regAddr,
  input  wire logic [7:0]          regWdata,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [7:0]          regRdata,
  // System outputs
  output logic                     cpuReset,
  output logic                     cpuTick,
  output logic                     extOscEnable,
  output logic                     ircEnable,
  output logic                     slowRcEnable,
  output cmrc_pkg::cmrc_mode_t     cpuMode,
  output logic                     slowActive
);
  import cmrc_pkg::*;

  localparam int PIN_RST  = 0;
  localparam int PIN_EXT  = 1;
  localparam int PIN_IRC  = 2;
  localparam int PIN_SLOW = 3;
  localparam int PIN_WAKE = 4;
  localparam logic [`CMRC_WARM_W-1:0] WARM_LAST = `CMRC_WARM_W'(WARMUP_EDGES - 1);

  cmrc_state_t st;
  cmrc_state_t next_st;

  logic [`CMRC_NPINS-1:0] pins;
  logic [`CMRC_NPINS-1:0] change;
  logic [`CMRC_NPINS-1:0] rise;
  logic                   hiEdge;
  logic                   srcEdge;
  logic [4:0]             fullN;
  logic [4:0]             limit;
  logic                   wrap;
  logic                   pinReset;

  assign pins = {wakeupPin, slowRcIn, ircIn, extOscIn, resetPinN};

  // One decode serves the write path, the read path and the checks.
  function automatic logic hitsModeReg(input logic [7:0] addr);
    return (addr == `CMRC_OMC_ADDR);
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // A pin level counts only once the second and third stages agree.
    for (int i = 0; i < `CMRC_NPINS; i++) begin
      next_st.syncs[i] = {st.syncs[i][1:0], pins[i]};
      change[i] = (st.syncs[i][1] == st.syncs[i][2]) && (st.syncs[i][2] != st.lvl[i]);
      rise[i]   = change[i] && st.syncs[i][2];
      if (change[i]) begin
        next_st.lvl[i] = st.syncs[i][2];
      end
    end
    hiEdge  = st.optExt ? rise[PIN_EXT] : rise[PIN_IRC];
    srcEdge = st.useSlow ? rise[PIN_SLOW] : hiEdge;
    fullN   = {1'b0, st.optDiv} + 5'h01;
    if (st.useSlow) begin
      limit = `CMRC_SLOW_DIV;
    end else if (st.optNf && fullN > `CMRC_NF_MAX_DIV) begin
      limit = `CMRC_NF_MAX_DIV;
    end else begin
      limit = fullN;
    end
    wrap     = srcEdge && (st.divCnt >= limit - 5'h01);
    pinReset = resetPinEnable && !st.lvl[PIN_RST];
    next_st.cpuTick = 1'b0;
    next_st.rdata   = 8'h00;

    unique case (st.seq)
      CMRC_HOLD: begin
        // Stay here while the pin is enabled and not yet seen high.
        if (!pinReset) begin
          next_st.seq = CMRC_INIT;
        end
      end
      CMRC_INIT: begin
        // Options are caught here so they cannot change mid-run.
        next_st.optExt  = highClockOption;
        next_st.optNf   = noiseFilter;
        next_st.optDiv  = divSelect;
        next_st.warmCnt = '0;
        next_st.seq     = CMRC_WARM;
      end
      CMRC_WARM: begin
        if (srcEdge) begin
          next_st.warmCnt = st.warmCnt + 1'b1;
          if (st.warmCnt == WARM_LAST) begin
            next_st.seq    = CMRC_RUN;
            next_st.divCnt = 5'h00;
          end
        end
      end
      CMRC_RUN: begin
        if (srcEdge) begin
          next_st.divCnt = wrap ? 5'h00 : st.divCnt + 5'h01;
        end
        // The source changes only at an instruction boundary, so no short pulse.
        if (wrap) begin
          next_st.useSlow = st.slowSel;
          next_st.cpuTick = (st.cpuMode == CMRC_NORMAL);
        end
        // A write cannot end sleep; only a wakeup or a reset may do that.
        if (regWrite && hitsModeReg(regAddr) && st.cpuMode != CMRC_SLEEP) begin
          next_st.highStop = regWdata[`CMRC_STOP_BIT];
          next_st.slowSel  = regWdata[`CMRC_SLOW_BIT];
          // The reserved code is refused and the mode is kept.
          if (regWdata[`CMRC_MODE_MSB:`CMRC_MODE_LSB] != CMRC_RSVD) begin
            next_st.cpuMode = cmrc_mode_t'(regWdata[`CMRC_MODE_MSB:`CMRC_MODE_LSB]);
          end
        end
        if (regRead && hitsModeReg(regAddr)) begin
          next_st.rdata = {3'h0, st.cpuMode, st.slowSel, st.highStop, 1'b0};
        end
        // A wakeup beats a write in the same cycle; sleep needs warm-up again.
        if (st.cpuMode != CMRC_NORMAL && change[PIN_WAKE]) begin
          next_st.cpuMode = CMRC_NORMAL;
          if (st.cpuMode == CMRC_SLEEP) begin
            next_st.seq     = CMRC_WARM;
            next_st.warmCnt = '0;
          end
        end
      end
    endcase

    if (st.seq == CMRC_INIT || pinReset || watchdogOverflow) begin
      next_st.highStop = 1'b0;
      next_st.slowSel  = 1'b0;
      next_st.cpuMode  = CMRC_NORMAL;
      next_st.useSlow  = 1'b0;
      next_st.divCnt   = 5'h00;
    end
    if (pinReset) begin
      next_st.seq = CMRC_HOLD;
    end else if (watchdogOverflow) begin
      next_st.seq = CMRC_INIT;
    end

    next_st.cpuReset = (next_st.seq != CMRC_RUN);
    next_st.loscEn   = (next_st.cpuMode != CMRC_SLEEP);
    next_st.extOscEn = next_st.loscEn && !next_st.highStop && next_st.optExt;
    next_st.ircEn    = next_st.loscEn && !next_st.highStop && !next_st.optExt;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st          <= '0;
      st.seq      <= CMRC_HOLD;
      st.cpuMode  <= CMRC_NORMAL;
      st.cpuReset <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata     = st.rdata;
  assign cpuReset     = st.cpuReset;
  assign cpuTick      = st.cpuTick;
  assign extOscEnable = st.extOscEn;
  assign ircEnable    = st.ircEn;
  assign slowRcEnable = st.loscEn;
  assign cpuMode      = st.cpuMode;
  assign slowActive   = st.useSlow;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_pin_holds_reset: assert property (
    resetPinEnable && !st.lvl[PIN_RST] |=> st.seq == CMRC_HOLD ##1 st.cpuReset)
    else $error("reset pin low did not hold the system");
  a_pin_ignored_off: assert property (
    !resetPinEnable && !watchdogOverflow && st.seq == CMRC_HOLD |=> st.seq == CMRC_INIT)
    else $error("disabled reset pin still held reset");
  a_hold_release: assert property (
    st.seq == CMRC_HOLD && st.lvl[PIN_RST] && !watchdogOverflow |=> st.seq == CMRC_INIT)
    else $error("reset not released after pin went high");
  a_wdog_reset: assert property (
    watchdogOverflow && !(resetPinEnable && !st.lvl[PIN_RST])
      |=> st.seq == CMRC_INIT && st.cpuMode == CMRC_NORMAL)
    else $error("watchdog overflow did not restart in normal mode");
  a_init_clears: assert property (
    st.seq == CMRC_INIT |=> !st.highStop && !st.slowSel && st.cpuReset ##1 st.seq != CMRC_RUN)
    else $error("registers not initialised during reset sequence");
  a_sleep_stops: assert property (
    st.cpuMode == CMRC_SLEEP |-> !st.loscEn && !st.extOscEn && !st.ircEn)
    else $error("oscillator running in sleep");
  a_stop_bit: assert property (
    st.highStop && st.cpuMode != CMRC_SLEEP |-> !st.extOscEn && !st.ircEn && st.loscEn)
    else $error("stop bit did not halt only the high oscillator");
  a_slow_div: assert property (
    st.useSlow |-> st.divCnt <= 5'h03)
    else $error("slow divider exceeds four");
  a_nf_div: assert property (
    st.optNf && !st.useSlow |-> st.divCnt <= 5'h03)
    else $error("noise filter divider exceeds four");
  a_div_range: assert property (
    st.seq == CMRC_RUN && !st.useSlow |-> st.divCnt <= {1'b0, st.optDiv})
    else $error("high divider beyond option");
  a_switch_clean: assert property (
    $changed(st.useSlow) && $past(st.seq) == CMRC_RUN |-> st.divCnt == 5'h00)
    else $error("clock source changed mid instruction cycle");
  a_mode_legal: assert property (
    st.cpuMode != CMRC_RSVD)
    else $error("reserved cpu mode entered");
  a_wake_normal: assert property (
    st.seq == CMRC_RUN && st.cpuMode == CMRC_SLEEP && change[PIN_WAKE] && !pinReset
      && !watchdogOverflow |=> st.cpuMode == CMRC_NORMAL && st.seq == CMRC_WARM)
    else $error("wakeup did not leave sleep");
  a_sleep_kept: assert property (
    st.cpuMode == CMRC_SLEEP && !change[PIN_WAKE] && !pinReset && !watchdogOverflow
      |=> st.cpuMode == CMRC_SLEEP)
    else $error("sleep left without wakeup or reset");
  a_write_taken: assert property (
    st.seq == CMRC_RUN && st.cpuMode != CMRC_SLEEP && regWrite && hitsModeReg(regAddr)
      && !pinReset && !watchdogOverflow |=> st.slowSel == $past(regWdata[`CMRC_SLOW_BIT]))
    else $error("clock-mode write not taken");
  a_reserved_keep: assert property (
    st.seq == CMRC_RUN && regWrite && hitsModeReg(regAddr) && !change[PIN_WAKE]
      && regWdata[`CMRC_MODE_MSB:`CMRC_MODE_LSB] == 2'b11 && !pinReset && !watchdogOverflow
      |=> st.cpuMode == $past(st.cpuMode))
    else $error("reserved mode code changed the mode");
  a_slow_select: assert property (
    st.seq == CMRC_RUN && wrap && !pinReset && !watchdogOverflow
      |=> st.useSlow == $past(st.slowSel))
    else $error("clock source not taken at instruction boundary");
  a_tick_mode: assert property (
    st.cpuTick |-> $past(st.seq) == CMRC_RUN && $past(st.cpuMode) == CMRC_NORMAL)
    else $error("instruction tick outside normal run");
  a_rdata_idle: assert property (
    !$past(regRead) |-> st.rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  a_high_src: assert property (
    !(st.extOscEn && st.ircEn))
    else $error("both high oscillators enabled");
  a_ext_only: assert property (
    st.extOscEn |-> st.optExt && !st.highStop)
    else $error("external oscillator enabled against option or stop bit");
  a_slow_osc_on: assert property (
    st.seq != CMRC_HOLD && st.cpuMode != CMRC_SLEEP |-> st.loscEn)
    else $error("slow oscillator stopped outside sleep");

  // ---------------------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------------------
  c_reach_run: cover property (st.seq == CMRC_WARM ##1 st.seq == CMRC_RUN);
  c_wdog_run: cover property (st.seq == CMRC_RUN && watchdogOverflow);
  c_sleep_wake: cover property (st.cpuMode == CMRC_SLEEP ##[1:200] st.cpuMode == CMRC_NORMAL);
  c_go_slow: cover property (!st.useSlow ##1 st.useSlow);
  c_capped_tick: cover property (st.optNf && st.cpuTick);

endmodule

// >>> dv/cmrc_reset_circuit.sv
// Behavioural model of the board reset circuit that drives the reset pin.
`timescale 1ns/100ps
module cmrc_reset_circuit #(
  parameter int RISE_CYCLES = 6
) (
  // Clock
  input  wire logic clk,
  // Request from the bench
  input  wire logic holdLow,
  // Pin
  output logic      resetPinN
);
  // The capacitor charges slowly, so the pin rises some cycles after release.
  int riseCnt;
  initial begin
    riseCnt   = 0;
    resetPinN = 1'b0;
  end
  always @(posedge clk) begin
    if (holdLow) begin
      riseCnt   <= 0;
      resetPinN <= 1'b0;
    end else if (riseCnt < RISE_CYCLES) begin
      riseCnt <= riseCnt + 1;
    end else begin
      resetPinN <= 1'b1;
    end
  end
endmodule

// >>> dv/tb_clock_mode_reset_control.sv
// Self-checking testbench of the clock and reset control.
`timescale 1ns/100ps
module tb_clock_mode_reset_control;
  import cmrc_pkg::*;
  localparam int EXT_P = 8;
  localparam int IRC_P = 16;
  localparam int SLOW_P = 64;
  logic clk, sys_rst, holdLow, resetPinN, extOscIn, ircIn, slowRcIn, wakeupPin;
  logic resetPinEnable, highClockOption, noiseFilter, watchdogOverflow, regWrite, regRead;
  logic [3:0] divSelect;
  logic [7:0] regAddr, regWdata, regRdata, oscCnt;
  logic cpuReset, cpuTick, extOscEnable, ircEnable, slowRcEnable, slowActive;
  cmrc_mode_t cpuMode;
  int failures, n_compared, cyc, g;
  cmrc_reset_circuit cmrc_reset_circuit_i (.clk(clk), .holdLow(holdLow), .resetPinN(resetPinN));
  cmrc_top #(.WARMUP_EDGES(4)) cmrc_top_i (.clk(clk), .sys_rst(sys_rst),
    .resetPinN(resetPinN), .extOscIn(extOscIn), .ircIn(ircIn), .slowRcIn(slowRcIn),
    .wakeupPin(wakeupPin), .resetPinEnable(resetPinEnable),
    .highClockOption(highClockOption), .noiseFilter(noiseFilter), .divSelect(divSelect),
    .watchdogOverflow(watchdogOverflow), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .cpuReset(cpuReset),
    .cpuTick(cpuTick), .extOscEnable(extOscEnable), .ircEnable(ircEnable),
    .slowRcEnable(slowRcEnable), .cpuMode(cpuMode), .slowActive(slowActive));
  initial begin
    clk = 0; sys_rst = 1; holdLow = 1; oscCnt = 8'h00; cyc = 0;
    {extOscIn, ircIn, slowRcIn, wakeupPin, watchdogOverflow, regWrite, regRead} = '0;
    resetPinEnable = 1; highClockOption = 1; noiseFilter = 0; divSelect = 4'h2;
    regAddr = 8'h00; regWdata = 8'h00; failures = 0; n_compared = 0;
  end
  always #20 clk = ~clk;
  // Oscillators are slow square waves so the pin synchronisers can follow them.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    oscCnt <= oscCnt + 8'h01;
    extOscIn <= oscCnt[2];
    ircIn <= oscCnt[3];
    slowRcIn <= oscCnt[5];
  end
  task automatic end_sim;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_sim();
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin regWrite <= 1; regAddr <= a; regWdata <= d; end
    @(posedge clk) regWrite <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk) begin regRead <= 1; regAddr <= a; end
    @(posedge clk) regRead <= 0;
    #1 chk(regRdata, exp, msg);
  endtask
  // Waits for cpuReset to reach a level; the bound covers pin rise and warm-up.
  task automatic wait_rst(input logic lvl, input string msg);
    int i;
    for (i = 0; i < 600 && cpuReset !== lvl; i++) @(posedge clk) #1;
    chk(cpuReset, lvl, msg);
  endtask
  task automatic gap_ticks(output int gap);
    int i, t0;
    for (i = 0; i < 2; i++) begin
      t0 = cyc;
      do @(posedge clk) #1; while (cpuTick !== 1'b1 && cyc - t0 < 1000);
      gap = cyc - t0;
    end
  endtask
  task automatic boot(input logic hco, input logic nf, input logic [3:0] dv);
    @(posedge clk) begin
      sys_rst <= 1; highClockOption <= hco; noiseFilter <= nf; divSelect <= dv;
    end
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    wait_rst(0, "boot");
  endtask
  task automatic t_pin;
    holdLow <= 1;
    repeat (30) @(posedge clk);
    #1 chk(cpuReset, 1, "held by pin");
    holdLow <= 0;
    wait_rst(0, "pin released");
    rd(8'hca, 8'h00, "init value");
    rd(8'h00, 8'h00, "unmapped read");
    @(posedge clk) holdLow <= 1;
    repeat (10) @(posedge clk);
    #1 chk(cpuReset, 1, "pin while running");
    holdLow <= 0;
    wait_rst(0, "running release");
  endtask
  task automatic t_div;
    boot(1, 0, 4'h2);
    gap_ticks(g);
    chk(g, 3 * EXT_P, "ext div 3");
    chk(extOscEnable, 1, "ext enabled");
    boot(0, 1, 4'h9);
    gap_ticks(g);
    chk(g, 4 * IRC_P, "capped div");
    chk(ircEnable, 1, "irc enabled");
    wr(8'hca, 8'h02);
    #1 chk({ircEnable, slowRcEnable}, 2'b01, "stop high");
    boot(1, 0, 4'h0);
  endtask
  task automatic t_slow;
    wr(8'hca, 8'h04);
    rd(8'hca, 8'h04, "slow readback");
    gap_ticks(g);
    gap_ticks(g);
    chk(slowActive, 1, "slow active");
    gap_ticks(g);
    chk(g, 4 * SLOW_P, "slow div 4");
    wr(8'hca, 8'h00);
    gap_ticks(g);
    gap_ticks(g);
    chk(g, EXT_P, "back to high");
  endtask
  task automatic t_modes;
    wr(8'hca, 8'h18);
    rd(8'hca, 8'h00, "reserved mode kept");
    wr(8'hca, 8'h10);
    #1 chk(cpuMode, CMRC_GREEN, "green");
    @(posedge clk) wakeupPin <= ~wakeupPin;
    repeat (10) @(posedge clk);
    #1 chk(cpuMode, CMRC_NORMAL, "green wake");
    wr(8'hca, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk(cpuMode, CMRC_SLEEP, "sleep");
    chk({extOscEnable, slowRcEnable}, 2'b00, "sleep stops oscs");
    g = 0;
    repeat (100) @(posedge clk) #1 if (cpuTick === 1'b1) g++;
    chk(g, 0, "no ticks asleep");
    chk(cpuMode, CMRC_SLEEP, "stays asleep");
    wr(8'hca, 8'h00);
    #1 chk(cpuMode, CMRC_SLEEP, "write refused asleep");
    @(posedge clk) wakeupPin <= ~wakeupPin;
    wait_rst(1, "wake warm");
    wait_rst(0, "wake run");
    repeat (10) @(posedge clk);
    #1 chk(cpuMode, CMRC_NORMAL, "wake normal");
  endtask
  task automatic t_wdog;
    wr(8'hca, 8'h06);
    @(posedge clk) watchdogOverflow <= 1;
    @(posedge clk) watchdogOverflow <= 0;
    repeat (2) @(posedge clk);
    #1 chk(cpuReset, 1, "watchdog reset");
    wait_rst(0, "watchdog done");
    rd(8'hca, 8'h00, "watchdog clears");
    chk(cpuMode, CMRC_NORMAL, "normal after watchdog");
    @(posedge clk) begin resetPinEnable <= 0; holdLow <= 1; end
    boot(1, 0, 4'h0);
    chk(cpuReset, 0, "pin disabled");
    @(posedge clk) resetPinEnable <= 1;
    repeat (10) @(posedge clk);
    #1 chk(cpuReset, 1, "pin enabled");
    holdLow <= 0;
    wait_rst(0, "final release");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    t_pin();
    t_div();
    t_slow();
    t_modes();
    t_wdog();
    end_sim();
  end
endmodule

// >>> include/cmrc_map.svh
// Register offsets, field positions, reset values and counts of the clock and reset control.
`ifndef CMRC_MAP_SVH
`define CMRC_MAP_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define CMRC_OMC_ADDR    8'hca
`define CMRC_OMC_RST     8'h00
`define CMRC_STOP_BIT    1
`define CMRC_SLOW_BIT    2
`define CMRC_MODE_LSB    3
`define CMRC_MODE_MSB    4

// -----------------------------------------------------------------------------
// Clock division, warm-up and pin count
// -----------------------------------------------------------------------------
`define CMRC_SLOW_DIV    5'h04
`define CMRC_NF_MAX_DIV  5'h04
`define CMRC_WARM_W      12
`define CMRC_WARM_EDGES  1024
`define CMRC_NPINS       5

`endif

// >>> include/cmrc_pkg.sv
// Types shared by the clock and reset control.
`include "cmrc_map.svh"
package cmrc_pkg;

  typedef enum logic [1:0] {
    CMRC_NORMAL = 2'b00,
    CMRC_SLEEP  = 2'b01,
    CMRC_GREEN  = 2'b10,
    CMRC_RSVD   = 2'b11
  } cmrc_mode_t;

  typedef enum logic [3:0] {
    CMRC_HOLD = 4'b0001,
    CMRC_INIT = 4'b0010,
    CMRC_WARM = 4'b0100,
    CMRC_RUN  = 4'b1000
  } cmrc_seq_t;

  typedef struct packed {
    logic [`CMRC_NPINS-1:0][2:0] syncs;
    logic [`CMRC_NPINS-1:0]      lvl;
    cmrc_seq_t                   seq;
    logic [`CMRC_WARM_W-1:0]     warmCnt;
    logic [4:0]                  divCnt;
    logic                        useSlow;
    logic                        highStop;
    logic                        slowSel;
    cmrc_mode_t                  cpuMode;
    logic                        optExt;
    logic                        optNf;
    logic [3:0]                  optDiv;
    logic                        cpuTick;
    logic                        cpuReset;
    logic                        extOscEn;
    logic                        ircEn;
    logic                        loscEn;
    logic [7:0]                  rdata;
  } cmrc_state_t;

endpackage
